/* File: src/comparator_dac_map.svh */
/*
  register offsets, field positions and reset values of the comparator
  and reference ladder control block.
  assumes an 8-bit register port with a 3-bit byte address.
*/
`ifndef COMPARATOR_DAC_MAP_SVH
`define COMPARATOR_DAC_MAP_SVH

// ==========================================================================
// register offsets
`define OFS_CONTROL_STATUS  3'h0
`define OFS_INPUT_SELECT    3'h1
`define OFS_DAC_CONTROL     3'h2
`define OFS_INPUT_PIN_EN    3'h3
`define OFS_IRQ_STATUS      3'h4
`define OFS_IRQ_CLEAR       3'h5
`define OFS_IRQ_ENABLE      3'h6

// ==========================================================================
// control/status field positions
`define CS_ON_BIT           7
`define CS_HYST_BIT         6
`define CS_FLAG_BIT         5
`define CS_IRQ_EN_BIT       4
`define CS_RESULT_BIT       3
`define CS_PIN_EN_BIT       2
`define CS_MODE_HI          1
`define CS_MODE_LO          0

// ==========================================================================
// input select, ladder control, pin enable and interrupt field positions
`define SEL_POS_HI          5
`define SEL_POS_LO          4
`define SEL_NEG_HI          1
`define SEL_NEG_LO          0
`define DAC_EN_BIT          7
`define DAC_REF_BIT         6
`define DAC_CODE_HI         5
`define DAC_CODE_LO         0
`define PIN_EN_HI           2
`define PIN_EN_LO           0
`define IRQ_EDGE_BIT        0

// ==========================================================================
// edge sensitivity codes and reset values
`define MODE_RISING         2'h1
`define MODE_BOTH           2'h3
`define RESET_BYTE          8'h00
`define RESET_BIT           1'h0

`endif

/* File: src/comparator_dac_pkg.sv */
/*
  types shared by the comparator and reference ladder control logic.
  assumes the map header supplies every numeric constant.
*/
package comparator_dac_pkg;

  // ========================================================================
  // field types
  typedef logic [1:0] input_sel_t;
  typedef logic [5:0] level_code_t;

  // ========================================================================
  // settings carried to the analog core, ladder and pads
  typedef struct packed {
    logic        comparator_on;
    logic        hysteresis_select;
    input_sel_t  positive_input_select;
    input_sel_t  negative_input_select;
    logic        ladder_enable;
    logic        ladder_reference_select;
    level_code_t ladder_level_code;
    logic [2:0]  analog_pin_enable;
  } analog_ctrl_s;

  // ========================================================================
  // register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;

endpackage

/* File: src/level_sync.sv */
/*
  two-stage synchroniser for one level.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps

module level_sync (
  input  wire logic ref_clk_in,
  input  wire logic reset_in,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_reg;

  // ========================================================================
  // first stage feeds only the second stage
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

/* File: src/comparator_dac_control.sv */
/*
  register and event logic for an analog comparator with a 6-bit
  reference ladder: byte registers, result synchronising, edge flag,
  interrupt and the settings driven to the analog core and pads.
  assumes the register master keeps strobes one cycle long and the
  raw comparator output may change at any time.
*/
// How it works
// - the result bit of control/status reads the synchronised result.
// - the result bit resets to zero and reads zero while switched off.
// - pin enable lets the result drive the pad, else the pad is idle.
// - sensitivity 00/10 falling, 01 rising, 11 both edges.
// - bits 5-4 of input select pick ext 0/1/2 or ladder as plus input.
// - bits 1-0 of input select pick the minus input the same way.
// - reserved bits read zero and ignore writes.
// - bit 7 of ladder control turns the ladder output on.
// - bit 6 of ladder control picks bandgap (0) or supply (1).
// - the 6-bit level code sets the ladder to ref/64 times code+1.
// - three pin enable bits each permit one external analog input.
// - bit 7 of control/status switches the comparator on.
// - a selected edge sets the flag; writing zero clears, one is no-op.
// - with the interrupt enable set, a set flag raises the request.
// - the raw result is synchronised before read-back and edge check.
`timescale 1ns/100ps
`include "comparator_dac_map.svh"

module comparator_dac_control
  import comparator_dac_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        reset_in,
  input  wire logic [2:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [7:0]       reg_rdata_out,
  input  wire logic        raw_compare_output_in,
  output analog_ctrl_s     analog_ctrl_out,
  output logic             result_pin_out,
  output logic             result_pin_oe_out,
  output logic             irq_out
);

  // ========================================================================
  // state
  reg_req_s   req;
  logic       sync_result;
  logic       prev_result_reg;
  logic       compare_result_reg;
  logic       edge_event_flag_reg;
  logic       edge_event_flag_next;
  logic       edge_irq_enable_reg;
  logic       result_pin_enable_reg;
  input_sel_t edge_sensitivity_reg;
  logic [7:0] rd_mux;

  // ========================================================================
  // request bundle and address decode
  assign req = '{addr: reg_addr_in, wdata: reg_wdata_in,
                 wr: reg_wr_in, rd: reg_rd_in};

  wire wr_cs     = req.wr && (req.addr == `OFS_CONTROL_STATUS);
  wire wr_sel    = req.wr && (req.addr == `OFS_INPUT_SELECT);
  wire wr_dac    = req.wr && (req.addr == `OFS_DAC_CONTROL);
  wire wr_pin    = req.wr && (req.addr == `OFS_INPUT_PIN_EN);
  wire wr_iclr   = req.wr && (req.addr == `OFS_IRQ_CLEAR);
  wire wr_ien    = req.wr && (req.addr == `OFS_IRQ_ENABLE);

  // ========================================================================
  // result synchroniser
  level_sync u_result_sync (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .async_in   (raw_compare_output_in),
    .sync_out   (sync_result)
  );

  // ========================================================================
  // edge detection, gated by the comparator switch
  wire is_on   = analog_ctrl_out.comparator_on;
  wire rising  = is_on && sync_result && !prev_result_reg;
  wire falling = is_on && !sync_result && prev_result_reg;

  // rising only for 01, both for 11, falling for 00 and 10
  wire edge_hit = (edge_sensitivity_reg == `MODE_RISING) ? rising :
                  (edge_sensitivity_reg == `MODE_BOTH) ? (rising || falling) :
                  falling;

  // flag clears on a zero write to control/status or a one to the clear
  // register; a new edge in the same cycle wins
  wire flag_clear = (wr_cs && !req.wdata[`CS_FLAG_BIT])
                  || (wr_iclr && req.wdata[`IRQ_EDGE_BIT]);
  assign edge_event_flag_next = edge_hit ? 1'b1 :
                                flag_clear ? 1'b0 :
                                edge_event_flag_reg;

  // ========================================================================
  // result tracking and edge flag
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      prev_result_reg     <= `RESET_BIT;
      compare_result_reg  <= `RESET_BIT;
      edge_event_flag_reg <= `RESET_BIT;
    end else begin
      prev_result_reg     <= sync_result;
      compare_result_reg  <= is_on && sync_result;
      edge_event_flag_reg <= edge_event_flag_next;
    end
  end

  // ========================================================================
  // control/status writable fields
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      analog_ctrl_out.comparator_on     <= `RESET_BIT;
      analog_ctrl_out.hysteresis_select <= `RESET_BIT;
      edge_irq_enable_reg               <= `RESET_BIT;
      result_pin_enable_reg             <= `RESET_BIT;
      edge_sensitivity_reg              <= 2'h0;
    end else if (wr_cs) begin
      analog_ctrl_out.comparator_on     <= req.wdata[`CS_ON_BIT];
      analog_ctrl_out.hysteresis_select <= req.wdata[`CS_HYST_BIT];
      edge_irq_enable_reg   <= req.wdata[`CS_IRQ_EN_BIT];
      result_pin_enable_reg <= req.wdata[`CS_PIN_EN_BIT];
      edge_sensitivity_reg  <= req.wdata[`CS_MODE_HI:`CS_MODE_LO];
    end else if (wr_ien) begin
      edge_irq_enable_reg <= req.wdata[`IRQ_EDGE_BIT];
    end
  end

  // ========================================================================
  // input select and pin enable; reserved bits are never stored
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      analog_ctrl_out.positive_input_select <= 2'h0;
      analog_ctrl_out.negative_input_select <= 2'h0;
      analog_ctrl_out.analog_pin_enable     <= 3'h0;
    end else begin
      if (wr_sel) begin
        analog_ctrl_out.positive_input_select <=
          req.wdata[`SEL_POS_HI:`SEL_POS_LO];
        analog_ctrl_out.negative_input_select <=
          req.wdata[`SEL_NEG_HI:`SEL_NEG_LO];
      end
      if (wr_pin) begin
        analog_ctrl_out.analog_pin_enable <=
          req.wdata[`PIN_EN_HI:`PIN_EN_LO];
      end
    end
  end

  // ========================================================================
  // ladder control, all bits writable
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      analog_ctrl_out.ladder_enable           <= `RESET_BIT;
      analog_ctrl_out.ladder_reference_select <= `RESET_BIT;
      analog_ctrl_out.ladder_level_code       <= 6'h00;
    end else if (wr_dac) begin
      analog_ctrl_out.ladder_enable <= req.wdata[`DAC_EN_BIT];
      analog_ctrl_out.ladder_reference_select <=
        req.wdata[`DAC_REF_BIT];
      // ladder taps code+1 sixty-fourths of the reference
      analog_ctrl_out.ladder_level_code <=
        req.wdata[`DAC_CODE_HI:`DAC_CODE_LO];
    end
  end

  // ========================================================================
  // read selection; unmapped offsets and reserved bits read zero
  wire [7:0] cs_view  = {analog_ctrl_out.comparator_on,
                         analog_ctrl_out.hysteresis_select,
                         edge_event_flag_reg, edge_irq_enable_reg,
                         compare_result_reg,
                         result_pin_enable_reg, edge_sensitivity_reg};
  wire [7:0] sel_view = {2'h0, analog_ctrl_out.positive_input_select,
                         2'h0, analog_ctrl_out.negative_input_select};
  wire [7:0] dac_view = {analog_ctrl_out.ladder_enable,
                         analog_ctrl_out.ladder_reference_select,
                         analog_ctrl_out.ladder_level_code};
  wire [7:0] pin_view = {5'h00, analog_ctrl_out.analog_pin_enable};

  always_comb begin
    unique case (req.addr)
      `OFS_CONTROL_STATUS: rd_mux = cs_view;
      `OFS_INPUT_SELECT:   rd_mux = sel_view;
      `OFS_DAC_CONTROL:    rd_mux = dac_view;
      `OFS_INPUT_PIN_EN:   rd_mux = pin_view;
      `OFS_IRQ_STATUS:     rd_mux = {7'h00, edge_event_flag_reg};
      `OFS_IRQ_ENABLE:     rd_mux = {7'h00, edge_irq_enable_reg};
      default:             rd_mux = `RESET_BYTE;
    endcase
  end

  // ========================================================================
  // registered outputs: read data, pad drive, interrupt
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      reg_rdata_out     <= `RESET_BYTE;
      result_pin_out    <= `RESET_BIT;
      result_pin_oe_out <= `RESET_BIT;
      irq_out           <= `RESET_BIT;
    end else begin
      reg_rdata_out     <= req.rd ? rd_mux : `RESET_BYTE;
      result_pin_out    <= result_pin_enable_reg
                           && is_on && sync_result;
      result_pin_oe_out <= result_pin_enable_reg;
      irq_out           <= edge_irq_enable_reg
                           && edge_event_flag_next;
    end
  end

endmodule

/* File: dv/comparator_dac_assertions.sv */
/* port checker for the comparator control block.
   assumes it is bound to comparator_dac_control. */
`timescale 1ns/100ps
module comparator_dac_checker
  import comparator_dac_pkg::*;
(
  input wire logic         ref_clk_in,
  input wire logic         reset_in,
  input wire logic [2:0]   reg_addr_in,
  input wire logic [7:0]   reg_wdata_in,
  input wire logic         reg_wr_in,
  input wire logic         reg_rd_in,
  input wire logic [7:0]   reg_rdata_out,
  input wire logic         raw_compare_output_in,
  input wire analog_ctrl_s analog_ctrl_out,
  input wire logic         result_pin_out,
  input wire logic         result_pin_oe_out,
  input wire logic         irq_out
);
  // ==================
  // decoded strobes
  wire logic [7:0]   d    = reg_wdata_in;
  wire analog_ctrl_s c    = analog_ctrl_out;
  wire logic         raw  = raw_compare_output_in;
  wire logic         wcs  = reg_wr_in && reg_addr_in == 3'h0;
  wire logic         wsel = reg_wr_in && reg_addr_in == 3'h1;
  wire logic         wdac = reg_wr_in && reg_addr_in == 3'h2;
  wire logic         wpin = reg_wr_in && reg_addr_in == 3'h3;
  wire logic         wclr = reg_wr_in && reg_addr_in == 3'h5;
  wire logic         wen  = reg_wr_in && reg_addr_in == 3'h6;
  wire logic         rcs  = reg_rd_in && reg_addr_in == 3'h0;

  // ==================
  // port relations
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  a_rdata_idle: assert property (
    !reg_rd_in |=> reg_rdata_out == 8'h00) else $error("rdata not idle");
  a_select_write: assert property (
    wsel |=> {c.positive_input_select, c.negative_input_select}
      == {$past(d[5:4]), $past(d[1:0])}) else $error("select lost");
  a_ladder_write: assert property (
    wdac |=> {c.ladder_enable, c.ladder_reference_select,
      c.ladder_level_code} == $past(d)) else $error("ladder lost");
  a_pin_write: assert property (
    wpin |=> c.analog_pin_enable == $past(d[2:0])) else $error("pins lost");
  a_sel_reserved: assert property (
    reg_rd_in && reg_addr_in == 3'h1 |=> (reg_rdata_out & 8'hcc) == 8'h00)
    else $error("select reserved set");
  a_pin_reserved: assert property (
    reg_rd_in && reg_addr_in == 3'h3 |=> (reg_rdata_out & 8'hf8) == 8'h00)
    else $error("pin reserved set");
  a_cs_write: assert property (
    wcs |=> c.comparator_on == $past(d[7]) ##1
      ($past(wcs) || result_pin_oe_out == $past(d[2], 2)))
    else $error("control lost");
  a_pin_quiet: assert property (
    !result_pin_oe_out && $past(!result_pin_oe_out) |-> !result_pin_out)
    else $error("pin driven while disabled");
  a_off_reads_zero: assert property (
    rcs && !c.comparator_on && !$past(c.comparator_on)
      |=> !reg_rdata_out[3]) else $error("result while off");
  a_irq_edge: assert property (
    $rose(irq_out) && !$past(reg_wr_in, 2) && !$past(reset_in, 5)
      |-> $past(raw, 3) != $past(raw, 4)) else $error("irq without edge");
  a_irq_clear: assert property (
    wclr && d[0] && $past(raw, 2) == $past(raw, 3) |=> !irq_out)
    else $error("flag not cleared");
  a_irq_mask: assert property (
    wen && !d[0] |-> ##2 !irq_out) else $error("masked irq high");
  c_irq: cover property ($rose(irq_out));
  c_pin: cover property (result_pin_out);
  c_result: cover property (rcs ##1 reg_rdata_out[3]);
endmodule

bind comparator_dac_control comparator_dac_checker u_chk (
  .ref_clk_in(ref_clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .raw_compare_output_in(raw_compare_output_in),
  .analog_ctrl_out(analog_ctrl_out), .result_pin_out(result_pin_out),
  .result_pin_oe_out(result_pin_oe_out), .irq_out(irq_out));

/* File: dv/comparator_core_model.sv */
/* behavioural analog core: compares the two selected inputs.
   assumes input levels in millivolts from the bench. */
`timescale 1ns/100ps
module comparator_core_model
  import comparator_dac_pkg::*;
#(
  parameter int SUPPLY_MV  = 6400,
  parameter int BANDGAP_MV = 3200
)
(
  input  wire logic             ref_clk_in,
  input  wire analog_ctrl_s     analog_ctrl_in,
  input  wire logic [2:0][12:0] ext_mv_in,
  output logic                  raw_out
);
  // ==================
  // input steering and ladder level
  logic toggle_reg = 1'b0;
  function automatic int level(input analog_ctrl_s c,
                               input logic [2:0][12:0] e,
                               input logic [1:0] s);
    if (s == 2'h3)
      return !c.ladder_enable ? 0 :
        (c.ladder_reference_select ? SUPPLY_MV : BANDGAP_MV) / 64
        * (int'(c.ladder_level_code) + 1);
    return c.analog_pin_enable[s] ? int'(e[s]) : 0;
  endfunction
  // output wanders while the core is switched off
  always @(posedge ref_clk_in) toggle_reg <= ~toggle_reg;
  assign raw_out = !analog_ctrl_in.comparator_on ? toggle_reg :
    level(analog_ctrl_in, ext_mv_in, analog_ctrl_in.positive_input_select)
    > level(analog_ctrl_in, ext_mv_in, analog_ctrl_in.negative_input_select);
endmodule

/* File: dv/comparator_dac_control_tb.sv */
/* self-checking bench for the comparator control block.
   assumes the core model drives the raw comparator result. */
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  fails++; $display("BAD %s exp %h got %h", n, e, g); end end
module comparator_dac_control_tb;
  import comparator_dac_pkg::*;
  logic             ref_clk_in = 1'b0;
  logic             reset_in   = 1'b1;
  logic [2:0]       reg_addr   = 3'h0;
  logic [7:0]       reg_wdata  = 8'h00;
  logic             reg_wr     = 1'b0;
  logic             reg_rd     = 1'b0;
  logic [2:0][12:0] ext_mv     = {13'd1000, 13'd2000, 13'd4000};
  logic [31:0]      seed       = 32'h2803;
  logic [7:0]       rdata;
  logic             raw;
  logic             pin;
  logic             pin_oe;
  logic             irq;
  analog_ctrl_s     ctrl;
  int               fails       = 0;
  int               checks_done = 0;

  // ==================
  // clock, design and core model
  always #10 ref_clk_in = ~ref_clk_in;
  comparator_dac_control u_dut (.ref_clk_in(ref_clk_in),
    .reset_in(reset_in), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata),
    .raw_compare_output_in(raw), .analog_ctrl_out(ctrl),
    .result_pin_out(pin), .result_pin_oe_out(pin_oe), .irq_out(irq));
  comparator_core_model u_core (.ref_clk_in(ref_clk_in),
    .analog_ctrl_in(ctrl), .ext_mv_in(ext_mv), .raw_out(raw));

  // ==================
  // helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // read-back of a written byte: reserved bits drop out
  function automatic logic [7:0] rb(input logic [2:0] a, input logic [7:0] d);
    return a == 3'h1 ? d & 8'h33 : a == 3'h3 ? d & 8'h07 : d;
  endfunction
  // register image rebuilt from the settings outputs
  function automatic logic [7:0] view(input logic [2:0] a);
    if (a == 3'h1)
      return {2'h0, ctrl.positive_input_select,
              2'h0, ctrl.negative_input_select};
    if (a == 3'h2)
      return {ctrl.ladder_enable, ctrl.ladder_reference_select,
              ctrl.ladder_level_code};
    return {5'h0, ctrl.analog_pin_enable};
  endfunction
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd <= 1'b0;
    #1 `CHK("read", e, rdata)
    @(posedge ref_clk_in);
  endtask
  // sync and flag latency is three edges, five leaves margin
  task automatic settle();
    repeat (5) @(posedge ref_clk_in);
  endtask
  task automatic final_report();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ==================
  // watchdog
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    fails++;
    final_report();
  end

  // ==================
  // main sequence
  initial begin
    logic [2:0] a;
    logic [7:0] d;
    logic [1:0] m;
    repeat (12) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    @(posedge ref_clk_in);
    for (int k = 0; k < 8; k++)
      rdc(3'(k), 8'h00);
    wr(3'h7, 8'hff);
    rdc(3'h7, 8'h00);
    for (int i = 0; i < 24; i++) begin
      a = 3'(1 + xs() % 3);
      d = 8'(xs());
      wr(a, d);
      rdc(a, rb(a, d));
      `CHK("ctl", rb(a, d), view(a))
    end
    wr(3'h3, 8'hff);
    wr(3'h1, 8'h30);
    wr(3'h2, 8'h9f);
    ext_mv[0] <= 13'd2400;
    wr(3'h0, 8'hb4);
    settle();
    wr(3'h5, 8'h01);
    rdc(3'h0, 8'h94);
    wr(3'h2, 8'hdf);
    settle();
    rdc(3'h0, 8'h9c);
    for (int k = 0; k < 4; k++) begin
      m = k[1:0];
      wr(3'h0, 8'hb4 | {6'h00, m});
      wr(3'h5, 8'h01);
      ext_mv[0] <= 13'd4000;
      settle();
      `CHK("fall", m != 2'h1, irq)
      rdc(3'h4, {7'h00, m != 2'h1});
      wr(3'h0, 8'h94 | {6'h00, m});
      `CHK("clr", 1'b0, irq)
      ext_mv[0] <= 13'd2400;
      settle();
      `CHK("rise", m[0], irq)
      `CHK("pin", 1'b1, pin)
      rdc(3'h0, {2'h2, m[0], 3'h7, m});
    end
    wr(3'h6, 8'h00);
    // the request output follows the stored enable one cycle later
    @(posedge ref_clk_in);
    `CHK("mask", 1'b0, irq)
    rdc(3'h4, 8'h01);
    wr(3'h6, 8'h01);
    wr(3'h5, 8'h00);
    `CHK("keep", 1'b1, irq)
    wr(3'h5, 8'h01);
    `CHK("gone", 1'b0, irq)
    wr(3'h0, 8'h47);
    ext_mv[0] <= 13'd4000;
    settle();
    rdc(3'h0, 8'h47);
    `CHK("off", 2'h1, {pin, pin_oe})
    wr(3'h0, 8'h00);
    // pad enable is registered from the stored pin enable bit
    @(posedge ref_clk_in);
    `CHK("oe", 1'b0, pin_oe)
    final_report();
  end
endmodule
